// >>> srm_params.svh
`ifndef SRM_PARAMS_SVH
`define SRM_PARAMS_SVH

`define SRM_ADDR_W            7
`define SRM_SPI_ADDR_W        15
`define SRM_OFS_POS_LO        7'h2C
`define SRM_OFS_POS_MID       7'h2D
`define SRM_OFS_POS_HI        7'h2E
`define SRM_OFS_FS_A_LO       7'h30
`define SRM_OFS_FS_A_HI       7'h31
`define SRM_OFS_FS_B_LO       7'h32
`define SRM_OFS_FS_B_HI       7'h33
`define SRM_OFS_REF_BYPASS    7'h38
`define SRM_OFS_MARKER_CTRL   7'h3B
`define SRM_FS_RESET          16'hA000
`define SRM_FS_MIN_RECOMMEND  16'h2000
`define SRM_CTRL_RESET        8'h00
`define SRM_BIT_REF_BYPASS    0
`define SRM_BIT_MARKER_RECV   0
`define SRM_BIT_MARKER_DC     1
`define SRM_POS_W             24
`define SRM_SPI_FRAME_BITS    24
`define SRM_SPI_HEAD_BITS     16
`define SRM_POS_RESET         24'h000000

`endif

// >>> srm_pkg.sv
package srm_pkg;
	typedef logic [7:0]  srm_byte_t;
	typedef logic [15:0] srm_fs_t;
	typedef logic [23:0] srm_pos_t;
	typedef logic [6:0]  srm_addr_t;
	typedef enum logic [2:0]
	{
		SRM_IDLE = 3'b001,
		SRM_HEAD = 3'b010,
		SRM_DATA = 3'b100
	} srm_spi_state_t;
endpackage : srm_pkg

// >>> srm_spi_slave.sv
`timescale 1ns/10ps
`include "srm_params.svh"

// serial port: 24-bit frame, r/w bit, 15-bit address, 8 data bits, msb first.
// spi pins are oversampled by clk; sclk must be slower than clk/4.
module srm_spi_slave
	import srm_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           sys_rst,
	input  wire logic           clk_en,
	input  wire logic           spi_cs_n,
	input  wire logic           spi_sclk,
	input  wire logic           spi_sdi,
	input  wire srm_pkg::srm_byte_t rd_data,
	output logic                spi_sdo,
	output logic                spi_sdo_oe,
	output srm_pkg::srm_addr_t  acc_addr,
	output logic                acc_addr_ok,
	output logic                wr_stb,
	output srm_pkg::srm_byte_t  wr_data
);
	import srm_pkg::*;

	logic [1:0]     cs_sync;
	logic [2:0]     sclk_sync;
	logic [1:0]     sdi_sync;
	logic [4:0]     bit_cnt;
	logic [22:0]    shift_in;
	logic           rd_mode;
	srm_byte_t      shift_out;
	srm_spi_state_t state;
	logic           rise;
	logic           fall;
	logic           cs_act;

	// bits [0] are first sync stages and are read only by stage [1]
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			cs_sync   <= 2'h3;
			sclk_sync <= 3'h0;
			sdi_sync  <= 2'h0;
		end
		else if (clk_en)
		begin
			cs_sync   <= {cs_sync[0], spi_cs_n};
			sclk_sync <= {sclk_sync[1:0], spi_sclk};
			sdi_sync  <= {sdi_sync[0], spi_sdi};
		end

	assign rise   = sclk_sync[1] & ~sclk_sync[2];
	assign fall   = ~sclk_sync[1] & sclk_sync[2];
	assign cs_act = ~cs_sync[1];

	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			state       <= SRM_IDLE;
			bit_cnt     <= 5'h0;
			shift_in    <= 23'h0;
			rd_mode     <= 1'b0;
			shift_out   <= 8'h0;
			acc_addr    <= 7'h0;
			acc_addr_ok <= 1'b0;
			wr_stb      <= 1'b0;
			wr_data     <= 8'h0;
			spi_sdo     <= 1'b0;
			spi_sdo_oe  <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_stb <= 1'b0;
			if (!cs_act)
			begin
				state      <= SRM_IDLE;
				bit_cnt    <= 5'h0;
				spi_sdo_oe <= 1'b0;
			end
			else
			begin
				case (state)
					SRM_IDLE:
						state <= SRM_HEAD;
					SRM_HEAD:
						if (rise)
						begin
							shift_in <= {shift_in[21:0], sdi_sync[1]};
							bit_cnt  <= bit_cnt + 5'h1;
							if (bit_cnt == 5'(`SRM_SPI_HEAD_BITS - 1))
							begin
								rd_mode     <= shift_in[14];
								acc_addr    <= {shift_in[5:0], sdi_sync[1]};
								// upper address bits must be zero to hit the bank
								acc_addr_ok <= (shift_in[13:6] == 8'h0);
								state       <= SRM_DATA;
							end
						end
					SRM_DATA:
						if (rise)
						begin
							shift_in <= {shift_in[21:0], sdi_sync[1]};
							bit_cnt  <= bit_cnt + 5'h1;
							// each data byte is its own access
							if (bit_cnt == 5'(`SRM_SPI_FRAME_BITS - 1))
							begin
								wr_stb  <= ~rd_mode & acc_addr_ok;
								wr_data <= {shift_in[6:0], sdi_sync[1]};
								state   <= SRM_HEAD;
								bit_cnt <= 5'h0;
							end
						end
						else if (fall)
						begin
							if (bit_cnt == 5'(`SRM_SPI_HEAD_BITS))
							begin
								spi_sdo    <= rd_data[7];
								shift_out  <= {rd_data[6:0], 1'b0};
								spi_sdo_oe <= rd_mode;
							end
							else
							begin
								spi_sdo   <= shift_out[7];
								shift_out <= {shift_out[6:0], 1'b0};
							end
						end
					default:
						state <= SRM_IDLE;
				endcase
			end
		end
endmodule : srm_spi_slave

// >>> srm_regs.sv
`timescale 1ns/10ps
`include "srm_params.svh"

module srm_regs
	import srm_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              sys_rst,
	input  wire logic              clk_en,
	input  wire logic              spi_cs_n,
	input  wire logic              spi_sclk,
	input  wire logic              spi_sdi,
	input  wire srm_pkg::srm_pos_t sync_capture_position,
	input  wire logic              sync_position_valid,
	output logic                   spi_sdo,
	output logic                   spi_sdo_oe,
	output srm_pkg::srm_fs_t       input_a_full_scale,
	output srm_pkg::srm_fs_t       input_b_full_scale,
	output logic                   reference_bypass,
	output logic                   marker_receiver_enable,
	output logic                   marker_dc_coupled_enable,
	output logic                   range_changed
);
	import srm_pkg::*;

	srm_addr_t acc_addr;
	logic      acc_addr_ok;
	logic      wr_stb;
	srm_byte_t wr_data;
	srm_byte_t rd_data;
	srm_pos_t  pos_hold;

	srm_spi_slave u_spi
	(
		.clk         (clk),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.spi_cs_n    (spi_cs_n),
		.spi_sclk    (spi_sclk),
		.spi_sdi     (spi_sdi),
		.rd_data     (rd_data),
		.spi_sdo     (spi_sdo),
		.spi_sdo_oe  (spi_sdo_oe),
		.acc_addr    (acc_addr),
		.acc_addr_ok (acc_addr_ok),
		.wr_stb      (wr_stb),
		.wr_data     (wr_data)
	);

	// status is held from the windowing logic (same clock) on each valid while clk_en is high, so a read can be torn
	// between bytes if a valid lands between them; no reset value is defined, zero is used for determinism
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			pos_hold <= `SRM_POS_RESET;
		else if (clk_en && sync_position_valid)
			pos_hold <= sync_capture_position;

	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			input_a_full_scale <= `SRM_FS_RESET;
			input_b_full_scale <= `SRM_FS_RESET;
			range_changed      <= 1'b0;
		end
		else if (clk_en)
		begin
			range_changed <= 1'b0;
			if (wr_stb)
			begin
				// any code is stored; codes below the recommended floor are accepted
				case (acc_addr)
					`SRM_OFS_FS_A_LO:
					begin
						input_a_full_scale[7:0] <= wr_data;
						range_changed           <= 1'b1;
					end
					`SRM_OFS_FS_A_HI:
					begin
						input_a_full_scale[15:8] <= wr_data;
						range_changed            <= 1'b1;
					end
					`SRM_OFS_FS_B_LO:
					begin
						input_b_full_scale[7:0] <= wr_data;
						range_changed           <= 1'b1;
					end
					`SRM_OFS_FS_B_HI:
					begin
						input_b_full_scale[15:8] <= wr_data;
						range_changed            <= 1'b1;
					end
					default:
						range_changed <= 1'b0;
				endcase
			end
		end

	// reserved bits are not stored, so they always read back as zero
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			reference_bypass         <= 1'b0;
			marker_receiver_enable   <= 1'b0;
			marker_dc_coupled_enable <= 1'b0;
		end
		else if (clk_en && wr_stb)
		begin
			if (acc_addr == `SRM_OFS_REF_BYPASS)
				reference_bypass <= wr_data[`SRM_BIT_REF_BYPASS];
			if (acc_addr == `SRM_OFS_MARKER_CTRL)
			begin
				marker_receiver_enable   <= wr_data[`SRM_BIT_MARKER_RECV];
				marker_dc_coupled_enable <= wr_data[`SRM_BIT_MARKER_DC];
			end
		end

	always_comb
	begin
		rd_data = 8'h0;
		if (acc_addr_ok)
		begin
			case (acc_addr)
				`SRM_OFS_POS_LO:      rd_data = pos_hold[7:0];
				`SRM_OFS_POS_MID:     rd_data = pos_hold[15:8];
				`SRM_OFS_POS_HI:      rd_data = pos_hold[23:16];
				`SRM_OFS_FS_A_LO:     rd_data = input_a_full_scale[7:0];
				`SRM_OFS_FS_A_HI:     rd_data = input_a_full_scale[15:8];
				`SRM_OFS_FS_B_LO:     rd_data = input_b_full_scale[7:0];
				`SRM_OFS_FS_B_HI:     rd_data = input_b_full_scale[15:8];
				`SRM_OFS_REF_BYPASS:  rd_data = {7'h0, reference_bypass};
				`SRM_OFS_MARKER_CTRL:
					rd_data = {6'h0, marker_dc_coupled_enable, marker_receiver_enable};
				default:              rd_data = 8'h0;
			endcase
		end
	end
endmodule : srm_regs

// >>> srm_regs_asserts.sv
`timescale 1ns/10ps
module srm_regs_asserts
	import srm_pkg::*;
(
	input wire logic              clk,
	input wire logic              sys_rst,
	input wire logic              clk_en,
	input wire logic              spi_cs_n,
	input wire logic              spi_sclk,
	input wire logic              spi_sdi,
	input wire srm_pkg::srm_pos_t sync_capture_position,
	input wire logic              sync_position_valid,
	input wire logic              spi_sdo,
	input wire logic              spi_sdo_oe,
	input wire srm_pkg::srm_fs_t  input_a_full_scale,
	input wire srm_pkg::srm_fs_t  input_b_full_scale,
	input wire logic              reference_bypass,
	input wire logic              marker_receiver_enable,
	input wire logic              marker_dc_coupled_enable,
	input wire logic              range_changed
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// eight idle cycles outlast the select synchroniser and a late write
	sequence s_idle;
		spi_cs_n [*8];
	endsequence
	AST_RST_FS: assert property ($fell(sys_rst)
		|-> {input_a_full_scale, input_b_full_scale} == 32'hA000A000) else $error("fs reset");
	AST_RST_CTL: assert property ($fell(sys_rst)
		|-> !(reference_bypass | marker_receiver_enable | marker_dc_coupled_enable))
		else $error("ctl reset");
	AST_OE_CS: assert property ($rose(spi_sdo_oe) |-> !spi_cs_n) else $error("oe no cs");
	AST_OE_OFF: assert property (s_idle |-> !spi_sdo_oe) else $error("oe idle");
	AST_IDLE_FS: assert property (s_idle
		|-> $stable({input_a_full_scale, input_b_full_scale})) else $error("fs moved");
	AST_IDLE_CTL: assert property (s_idle
		|-> $stable({reference_bypass, marker_receiver_enable, marker_dc_coupled_enable}))
		else $error("ctl moved");
	AST_FREEZE: assert property (!clk_en
		|=> $stable({input_a_full_scale, input_b_full_scale, spi_sdo_oe})) else $error("frozen");
	AST_PULSE: assert property (range_changed |=> !range_changed) else $error("pulse");
endmodule : srm_regs_asserts

bind srm_regs srm_regs_asserts u_srm_regs_asserts (.*);

// >>> srm_regs_test.sv
`timescale 1ns/10ps
module srm_regs_test;
	import srm_pkg::*;
	logic        clk = 0, sys_rst = 1, clk_en = 1, spi_cs_n = 1, spi_sclk = 0, spi_sdi = 0;
	logic        sync_position_valid = 0, spi_sdo, spi_sdo_oe, range_changed;
	logic        reference_bypass, marker_receiver_enable, marker_dc_coupled_enable;
	srm_pos_t    sync_capture_position = 24'h000000;
	srm_fs_t     input_a_full_scale, input_b_full_scale;
	logic [31:0] seed = 32'h7CB7E0BA, r;
	logic [23:0] q;
	logic [7:0]  mdl [128] = '{default: 8'h00};
	logic [14:0] tbl [11] = '{15'h2C, 15'h2D, 15'h2E, 15'h30, 15'h31, 15'h32, 15'h33,
		15'h34, 15'h38, 15'h3B, 15'h130};
	int          bad_count = 0, checked = 0, cyc = 0, pulses = 0, fs_wr = 0, k;

	srm_regs u_srm_regs (.*);

	always #20 clk = ~clk;

	always @(negedge clk)
	begin
		cyc++;
		if (range_changed === 1'b1)
			pulses++;
		if (cyc == 60000)
		begin
			bad_count++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic logic [7:0] msk(input logic [6:0] a);
		case (a)
			7'h30, 7'h31, 7'h32, 7'h33: return 8'hFF;
			7'h38: return 8'h01;
			7'h3B: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction : msk

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// sclk phases of 4 clk give twice the minimum the synchroniser needs
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d);
		logic [23:0] f;
		logic        oe_s;
		f = {rd, a, d};
		oe_s = 1'b0;
		spi_cs_n = 0;
		for (int i = 23; i >= 0; i--)
		begin
			spi_sclk = 0;
			spi_sdi = f[i];
			repeat (4) @(negedge clk);
			spi_sclk = 1;
			repeat (4) @(negedge clk);
			q[i] = spi_sdo;
			if (i == 0)
				oe_s = spi_sdo_oe;
		end
		spi_sclk = 0;
		repeat (8) @(negedge clk);
		spi_cs_n = 1;
		repeat (8) @(negedge clk);
		chk({14'h0000, oe_s, spi_sdo_oe}, {14'h0000, rd & clk_en, 1'b0});
		if (!rd && clk_en && a[14:7] == 8'h00 && msk(a[6:0]) != 8'h00)
		begin
			mdl[a[6:0]] = d & msk(a[6:0]);
			fs_wr += (a[6:2] == 5'h0C);
		end
	endtask : xfer

	task automatic rd_chk(input logic [14:0] a);
		xfer(1, a, 8'h00);
		chk({8'h00, q[7:0]}, a[14:7] == 8'h00 ? {8'h00, mdl[a[6:0]]} : 16'h0000);
	endtask : rd_chk

	task automatic ports();
		chk(input_a_full_scale, {mdl[7'h31], mdl[7'h30]});
		chk(input_b_full_scale, {mdl[7'h33], mdl[7'h32]});
		chk({13'h0000, marker_dc_coupled_enable, marker_receiver_enable, reference_bypass},
			{13'h0000, mdl[7'h3B][1:0], mdl[7'h38][0]});
	endtask : ports

	task tally_and_finish();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		mdl[7'h31] = 8'hA0;
		mdl[7'h33] = 8'hA0;
		repeat (6) @(negedge clk);
		sys_rst = 0;
		repeat (2) @(negedge clk);
		ports();
		foreach (tbl[i])
			rd_chk(tbl[i]);
		r = xs();
		sync_capture_position = r[23:0];
		sync_position_valid = 1;
		@(negedge clk);
		sync_position_valid = 0;
		sync_capture_position = ~r[23:0];
		{mdl[7'h2E], mdl[7'h2D], mdl[7'h2C]} = r[23:0];
		xfer(0, 15'h2D, 8'h5A);
		foreach (tbl[i])
			rd_chk(tbl[i]);
		xfer(0, 15'h31, 8'hFF);
		xfer(0, 15'h30, 8'hFF);
		xfer(0, 15'h33, 8'h20);
		xfer(0, 15'h32, 8'h00);
		ports();
		clk_en = 0;
		xfer(0, 15'h30, 8'h55);
		clk_en = 1;
		ports();
		// every bit set: reserved bits must drop, the defined ones must stick
		xfer(0, 15'h38, 8'hFF);
		xfer(0, 15'h3B, 8'hFF);
		ports();
		rd_chk(15'h38);
		rd_chk(15'h3B);
		for (int n = 0; n < 40; n++)
		begin
			r = xs();
			k = r[19:16] % 11;
			// odd addresses get bit 5 so high range bytes never go below 0x20
			if (r[20])
			begin
				sync_capture_position = r[31:8];
				sync_position_valid = 1;
				{mdl[7'h2E], mdl[7'h2D], mdl[7'h2C]} = r[31:8];
				@(negedge clk);
				sync_position_valid = 0;
			end
			xfer(0, tbl[k], r[15:8] | {2'b00, tbl[k][0], 5'h00});
			rd_chk(tbl[k]);
			ports();
		end
		chk(pulses[15:0], fs_wr[15:0]);
		// reset in mid-run must bring every register back to its reset value
		sys_rst = 1;
		repeat (2) @(negedge clk);
		sys_rst = 0;
		mdl = '{default: 8'h00};
		mdl[7'h31] = 8'hA0;
		mdl[7'h33] = 8'hA0;
		repeat (2) @(negedge clk);
		ports();
		rd_chk(15'h2C);
		rd_chk(15'h31);
		tally_and_finish();
	end
endmodule : srm_regs_test
